// ---- rtl/dcec_top.sv ----
// channel event control block with wishbone register port
// Operation
// - abort number field 23-16; its interrupt aborts transfer and sets abort flag
// - start number field 15-8 selects interrupt that starts a transfer
// - start enable bit 4 gates the start interrupt
// - abort enable bit 3 gates the abort interrupt
// - writing one to bit 7 forces a transfer start
// - writing one to bit 6 forces a transfer abort
// - bits 7 and 6 are strobes and always read zero
// - pattern abort enable bit 5: match aborts and clears channel enable
// - bits 31-24 and 2-0 ignore writes, read zero
// - reset: number fields all ones, strobes and enables zero
// - clear, set and invert aliases at 0x4, 0x8, 0xc
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
`include "dcec_defs.svh"
module dcec_top #(
  parameter int NUM_IRQ = 256
) (
  input  wire logic               REF_CLK,     // system clock
  input  wire logic               SYS_RST,     // async reset, high
  input  wire logic [31:0]        WB_ADR_I,    // byte address
  input  wire logic [31:0]        WB_DAT_I,    // write data
  output logic      [31:0]        WB_DAT_O,    // read data
  input  wire logic [3:0]         WB_SEL_I,    // byte lanes
  input  wire logic               WB_WE_I,     // write
  input  wire logic               WB_CYC_I,    // cycle
  input  wire logic               WB_STB_I,    // strobe
  output logic                    WB_ACK_O,    // acknowledge
  input  wire logic [NUM_IRQ-1:0] IRQ_LINES,   // interrupt sources
  input  wire logic               PAT_MATCH,   // pattern match pulse
  output logic                    START_REQ,   // start to engine
  output logic                    ABORT_REQ,   // abort to engine
  output logic                    CHAN_ABORT_FLAG, // channel abort flag
  output logic                    CHAN_BUSY,   // transfer running
  output logic                    IRQ          // interrupt out
);
  logic [31:0] econ_reg;
  logic        chan_en_reg;
  logic        abort_flag_reg;
  logic [`DCEC_ST_WIDTH-1:0] stat_reg;
  logic [`DCEC_ST_WIDTH-1:0] mask_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic        start_q_reg;
  logic        abort_q_reg;
  logic        busy_q_reg;
  logic        irq_reg;
  logic        force_start;
  logic        force_abort;
  logic        busy;
  logic        start_go;
  logic        abort_go;
  logic        wr_stb;
  logic [31:0] wmask;
  logic [31:0] wdata;
  logic [31:0] econ_next;
  logic [`DCEC_ST_WIDTH-1:0] events;
  logic        plain_hit;
  logic        clr_hit;
  logic        set_hit;
  logic        inv_hit;
  logic        stat_wr;
  logic        mask_wr;
  logic        chan_wr;
  logic        rd_req;

  dcec_req_if req_bus ();

  // ============================================================
  // byte-lane mask from sel
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // full address match on one view of the event control register
  function automatic logic econ_view(input logic [31:0] adr, input logic [3:0] off);
    econ_view = (adr[31:4] == 28'h0) && (adr[3:0] == off);
  endfunction

  // low-byte match on the status, mask and channel registers
  function automatic logic reg_view(input logic [31:0] adr, input logic [7:0] off);
    reg_view = (adr[7:0] == off);
  endfunction

  assign wr_stb    = WB_CYC_I & WB_STB_I & WB_WE_I & ~ack_reg;
  assign rd_req    = WB_CYC_I & WB_STB_I & ~WB_WE_I & ~ack_reg;
  assign wmask     = lane_mask(WB_SEL_I);
  assign wdata     = WB_DAT_I & wmask;
  assign plain_hit = wr_stb & econ_view(WB_ADR_I, `DCEC_OFF_ECON);
  assign clr_hit   = wr_stb & econ_view(WB_ADR_I, `DCEC_OFF_ECON_CLR);
  assign set_hit   = wr_stb & econ_view(WB_ADR_I, `DCEC_OFF_ECON_SET);
  assign inv_hit   = wr_stb & econ_view(WB_ADR_I, `DCEC_OFF_ECON_INV);
  assign stat_wr   = wr_stb & reg_view(WB_ADR_I, `DCEC_OFF_IRQ_STAT) & WB_SEL_I[0];
  assign mask_wr   = wr_stb & reg_view(WB_ADR_I, `DCEC_OFF_IRQ_MASK) & WB_SEL_I[0];
  assign chan_wr   = wr_stb & reg_view(WB_ADR_I, `DCEC_OFF_CHAN) & WB_SEL_I[0];

  // clear alias leaves the strobes alone
  assign force_start = (plain_hit | set_hit | inv_hit) & wdata[`DCEC_BIT_FORCE_ST];
  assign force_abort = (plain_hit | set_hit | inv_hit) & wdata[`DCEC_BIT_FORCE_AB];

  // ============================================================
  // event control register with aliases
  always_comb begin
    econ_next = econ_reg;
    if (wr_stb && WB_ADR_I[31:4] == 28'h0) begin
      case (WB_ADR_I[3:0])
        `DCEC_OFF_ECON:     econ_next = (econ_reg & ~wmask) | wdata; // plain write
        `DCEC_OFF_ECON_CLR: econ_next = econ_reg & ~wdata;
        `DCEC_OFF_ECON_SET: econ_next = econ_reg | wdata;
        `DCEC_OFF_ECON_INV: econ_next = econ_reg ^ wdata;
        default:            econ_next = econ_reg;
      endcase
    end
    econ_next = econ_next & `DCEC_ECON_RW_MASK;
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      econ_reg <= {8'h00, `DCEC_NUM_RESET, `DCEC_NUM_RESET, 8'h00};
    end else begin
      econ_reg <= econ_next;
    end
  end

  // ============================================================
  // channel enable: software sets, pattern abort clears
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      chan_en_reg <= 1'b0;
    end else if (req_bus.pat_abort) begin
      chan_en_reg <= 1'b0;
    end else if (chan_wr) begin
      chan_en_reg <= WB_DAT_I[`DCEC_CHAN_EN_BIT];
    end
  end

  // ============================================================
  // abort flag: set by abort, cleared by status write; set wins
  assign events = {PAT_MATCH & econ_reg[`DCEC_BIT_PAT_EN], start_go, abort_go};

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      stat_reg <= '0;
    end else if (stat_wr) begin
      stat_reg <= (stat_reg & ~WB_DAT_I[`DCEC_ST_WIDTH-1:0]) | events;
    end else begin
      stat_reg <= stat_reg | events;
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      abort_flag_reg <= 1'b0;
    end else begin
      abort_flag_reg <= stat_reg[`DCEC_ST_ABORT] | events[`DCEC_ST_ABORT];
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mask_reg <= '0;
    end else if (mask_wr) begin
      mask_reg <= WB_DAT_I[`DCEC_ST_WIDTH-1:0];
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(stat_reg & mask_reg);
    end
  end

  // ============================================================
  // trigger decode and sequencer
  dcec_trig #(.NUM_IRQ(NUM_IRQ)) u_trig (
    .clk         (REF_CLK),
    .rst         (SYS_RST),
    .irq_lines   (IRQ_LINES),
    .econ        (econ_reg),
    .force_start (force_start),
    .force_abort (force_abort),
    .pat_match   (PAT_MATCH),
    .req         (req_bus.src)
  );

  dcec_seq u_seq (
    .clk      (REF_CLK),
    .rst      (SYS_RST),
    .chan_en  (chan_en_reg),
    .req      (req_bus.dst),
    .busy     (busy),
    .start_go (start_go),
    .abort_go (abort_go)
  );

  // ============================================================
  // registered outputs toward the engine
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      start_q_reg <= 1'b0;
      abort_q_reg <= 1'b0;
      busy_q_reg  <= 1'b0;
    end else begin
      start_q_reg <= start_go;
      abort_q_reg <= abort_go;
      busy_q_reg  <= busy;
    end
  end

  // ============================================================
  // wishbone slave: one wait state, unmapped reads zero
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= WB_CYC_I & WB_STB_I & ~ack_reg;
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rdata_reg <= '0;
    end else if (WB_CYC_I && WB_STB_I && !ack_reg) begin
      case (WB_ADR_I[7:0])
        {4'h0, `DCEC_OFF_ECON}, {4'h0, `DCEC_OFF_ECON_CLR},
        {4'h0, `DCEC_OFF_ECON_SET}, {4'h0, `DCEC_OFF_ECON_INV}: rdata_reg <= econ_reg;
        `DCEC_OFF_IRQ_STAT: rdata_reg <= {29'h0, stat_reg};
        `DCEC_OFF_IRQ_MASK: rdata_reg <= {29'h0, mask_reg};
        `DCEC_OFF_CHAN:     rdata_reg <= {30'h0, busy, chan_en_reg};
        default:            rdata_reg <= '0;
      endcase
    end
  end

  assign WB_ACK_O        = ack_reg;
  assign WB_DAT_O        = rdata_reg;
  assign START_REQ       = start_q_reg;
  assign ABORT_REQ       = abort_q_reg;
  assign CHAN_ABORT_FLAG = abort_flag_reg;
  assign CHAN_BUSY       = busy_q_reg;
  assign IRQ             = irq_reg;

  // ============================================================
  // event control register checks
  a_strobe_reads0: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    econ_reg[`DCEC_BIT_FORCE_ST:`DCEC_BIT_FORCE_AB] == 2'b00)
    else $error("force strobes held in register");
  a_unused_zero: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    econ_reg[31:24] == 8'h00 && econ_reg[2:0] == 3'h0)
    else $error("unimplemented bits nonzero");
  a_plain_write: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    plain_hit |=> econ_reg == ((($past(econ_reg) & ~$past(wmask)) | $past(wdata)) & `DCEC_ECON_RW_MASK))
    else $error("plain write failed");
  a_clr_alias: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    clr_hit |=> (econ_reg & $past(wdata)) == 32'h0)
    else $error("clear alias failed");
  a_set_alias: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    set_hit |=> ((econ_reg & $past(wdata) & `DCEC_ECON_RW_MASK) == ($past(wdata) & `DCEC_ECON_RW_MASK)))
    else $error("set alias failed");
  a_inv_alias: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    inv_hit |=> econ_reg == (($past(econ_reg) ^ $past(wdata)) & `DCEC_ECON_RW_MASK))
    else $error("invert alias failed");
  a_econ_steady: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !(plain_hit || clr_hit || set_hit || inv_hit) |=> $stable(econ_reg))
    else $error("event control changed without write");
  a_econ_readback: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (rd_req && econ_view(WB_ADR_I, `DCEC_OFF_ECON)) |=> WB_DAT_O == $past(econ_reg))
    else $error("event control read wrong");

  // ============================================================
  // register port checks
  a_ack_pulse: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
    else $error("request not answered");
  a_ack_asked: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  a_dat_hold: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !(WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> $stable(WB_DAT_O))
    else $error("read data moved while idle");
  a_read_stat: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (rd_req && reg_view(WB_ADR_I, `DCEC_OFF_IRQ_STAT)) |=> WB_DAT_O == {29'h0, $past(stat_reg)})
    else $error("status read wrong");
  a_read_chan: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (rd_req && reg_view(WB_ADR_I, `DCEC_OFF_CHAN)) |=> WB_DAT_O == {30'h0, $past(busy), $past(chan_en_reg)})
    else $error("channel read wrong");

  // ============================================================
  // status, mask and interrupt checks
  a_stat_sticky: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !stat_wr |=> (($past(stat_reg) & ~stat_reg) == '0))
    else $error("status bit dropped without clear");
  a_set_wins: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (|events) |=> ((stat_reg & $past(events)) == $past(events)))
    else $error("event lost against clear");
  a_w1c_clear: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    stat_wr |=> ((stat_reg & $past(WB_DAT_I[`DCEC_ST_WIDTH-1:0] & ~events)) == '0))
    else $error("status clear failed");
  a_mask_write: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    mask_wr |=> mask_reg == $past(WB_DAT_I[`DCEC_ST_WIDTH-1:0]))
    else $error("mask write failed");
  a_irq_level: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    1'b1 |=> IRQ == $past(|(stat_reg & mask_reg)))
    else $error("interrupt level wrong");
  a_flag_follows: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    stat_reg[`DCEC_ST_ABORT] |=> CHAN_ABORT_FLAG)
    else $error("abort flag not shown");
  a_pat_stat: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    req_bus.pat_abort |=> stat_reg[`DCEC_ST_PAT])
    else $error("pattern abort not recorded");
  a_start_stat: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    start_go |=> stat_reg[`DCEC_ST_START])
    else $error("start not recorded");

  // ============================================================
  // channel checks
  a_pat_clears_en: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (PAT_MATCH && econ_reg[`DCEC_BIT_PAT_EN]) |=> !chan_en_reg)
    else $error("pattern abort left channel enabled");
  a_chan_write: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (chan_wr && !req_bus.pat_abort) |=> chan_en_reg == $past(WB_DAT_I[`DCEC_CHAN_EN_BIT]))
    else $error("channel enable write failed");
  a_start_needs_en: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    START_REQ |-> $past(chan_en_reg))
    else $error("start with channel disabled");
  a_force_start: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (force_start && chan_en_reg && !abort_go) |=> START_REQ ##1 CHAN_BUSY)
    else $error("forced start not issued");
  a_abort_flag: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    abort_go |-> ##1 ABORT_REQ ##1 CHAN_ABORT_FLAG)
    else $error("abort flag not set");
  a_abort_stops: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    ABORT_REQ |=> !CHAN_BUSY)
    else $error("transfer running after abort");
  a_no_start_abort: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !(START_REQ && ABORT_REQ))
    else $error("start and abort together");
endmodule

// ---- rtl/dcec_defs.svh ----
// constants for the channel event control block
`ifndef DCEC_DEFS_SVH
`define DCEC_DEFS_SVH

// ============================================================
// register byte offsets
`define DCEC_OFF_ECON      4'h0
`define DCEC_OFF_ECON_CLR  4'h4
`define DCEC_OFF_ECON_SET  4'h8
`define DCEC_OFF_ECON_INV  4'hc
`define DCEC_OFF_IRQ_STAT  8'h10
`define DCEC_OFF_IRQ_MASK  8'h14
`define DCEC_OFF_CHAN      8'h18

// ============================================================
// event control fields
`define DCEC_ABORT_NUM_HI  23
`define DCEC_ABORT_NUM_LO  16
`define DCEC_START_NUM_HI  15
`define DCEC_START_NUM_LO  8
`define DCEC_BIT_FORCE_ST  7
`define DCEC_BIT_FORCE_AB  6
`define DCEC_BIT_PAT_EN    5
`define DCEC_BIT_START_EN  4
`define DCEC_BIT_ABORT_EN  3
`define DCEC_ECON_RW_MASK  32'h00ff_ff38
`define DCEC_NUM_RESET     8'hff

// ============================================================
// status bits
`define DCEC_ST_ABORT      0
`define DCEC_ST_START      1
`define DCEC_ST_PAT        2
`define DCEC_ST_WIDTH      3
`define DCEC_CHAN_EN_BIT   0
`define DCEC_CHAN_BUSY_BIT 1

`endif

// ---- rtl/dcec_pkg.sv ----
// types for the channel event control block
package dcec_pkg;
  typedef enum logic [1:0] {
    DCEC_IDLE,
    DCEC_RUN
  } dcec_state_e;
  typedef logic [7:0] dcec_irq_num_t;
endpackage

// ---- rtl/dcec_req_if.sv ----
// request bundle between trigger decode and channel sequencer
`timescale 1ns/10ps
interface dcec_req_if;
  logic start_req;
  logic abort_req;
  logic pat_abort;
  modport src (output start_req, output abort_req, output pat_abort);
  modport dst (input start_req, input abort_req, input pat_abort);
endinterface

// ---- rtl/dcec_trig.sv ----
// trigger selection: picks start and abort interrupt lines
`timescale 1ns/10ps
`include "dcec_defs.svh"
module dcec_trig #(
  parameter int NUM_IRQ = 256
) (
  input  wire logic                   clk,         // system clock
  input  wire logic                   rst,         // async reset
  input  wire logic [NUM_IRQ-1:0]     irq_lines,   // interrupt sources
  input  wire logic [31:0]            econ,        // event control value
  input  wire logic                   force_start, // write strobe
  input  wire logic                   force_abort, // write strobe
  input  wire logic                   pat_match,   // pattern match pulse
  dcec_req_if.src                     req          // to sequencer
);
  logic [NUM_IRQ-1:0] irq_prev_reg;
  dcec_pkg::dcec_irq_num_t start_num;
  dcec_pkg::dcec_irq_num_t abort_num;
  logic start_hit;
  logic abort_hit;

  // ============================================================
  // rising edge detect on the selected start and abort interrupt lines
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_prev_reg <= '0;
    end else begin
      irq_prev_reg <= irq_lines;
    end
  end

  assign start_num = econ[`DCEC_START_NUM_HI:`DCEC_START_NUM_LO];
  assign abort_num = econ[`DCEC_ABORT_NUM_HI:`DCEC_ABORT_NUM_LO];
  assign start_hit = irq_lines[start_num] & ~irq_prev_reg[start_num];
  assign abort_hit = irq_lines[abort_num] & ~irq_prev_reg[abort_num];

  assign req.start_req = (start_hit & econ[`DCEC_BIT_START_EN]) | force_start;
  assign req.abort_req = (abort_hit & econ[`DCEC_BIT_ABORT_EN]) | force_abort;
  assign req.pat_abort = pat_match & econ[`DCEC_BIT_PAT_EN];

  a_start_gated: assert property (@(posedge clk) disable iff (rst)
    (req.start_req && !force_start) |-> econ[`DCEC_BIT_START_EN])
    else $error("start request without start enable");
  a_abort_gated: assert property (@(posedge clk) disable iff (rst)
    (req.abort_req && !force_abort) |-> econ[`DCEC_BIT_ABORT_EN])
    else $error("abort request without abort enable");
  a_pat_gated: assert property (@(posedge clk) disable iff (rst)
    req.pat_abort |-> econ[`DCEC_BIT_PAT_EN])
    else $error("pattern abort while disabled");
endmodule

// ---- rtl/dcec_seq.sv ----
// channel sequencer: running state and abort priority
`timescale 1ns/10ps
module dcec_seq (
  input  wire logic clk,        // system clock
  input  wire logic rst,        // async reset
  input  wire logic chan_en,    // channel enable
  dcec_req_if.dst   req,        // trigger requests
  output logic      busy,       // transfer running
  output logic      start_go,   // start accepted this cycle
  output logic      abort_go    // abort taken this cycle
);
  dcec_pkg::dcec_state_e state_reg;
  logic any_abort;

  assign any_abort = req.abort_req | req.pat_abort;
  assign abort_go  = any_abort;
  assign start_go  = req.start_req & chan_en & ~any_abort;
  assign busy      = (state_reg == dcec_pkg::DCEC_RUN);

  // ============================================================
  // run state; abort wins over start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= dcec_pkg::DCEC_IDLE;
    end else begin
      case (state_reg)
        dcec_pkg::DCEC_IDLE: begin
          if (start_go) begin
            state_reg <= dcec_pkg::DCEC_RUN;
          end
        end
        dcec_pkg::DCEC_RUN: begin
          if (any_abort || !chan_en) begin
            state_reg <= dcec_pkg::DCEC_IDLE;
          end
        end
        default: state_reg <= dcec_pkg::DCEC_IDLE;
      endcase
    end
  end

  a_abort_wins: assert property (@(posedge clk) disable iff (rst)
    any_abort |=> !busy)
    else $error("transfer still running after abort");
endmodule

// ---- testbench/dcec_far_model.sv ----
// model of the interrupt sources and the transfer engine around the block
`timescale 1ns/10ps
module dcec_far_model (
  input  wire logic         clk,       // system clock
  input  wire logic [7:0]   fire_num,  // line to pulse
  input  wire logic         fire,      // pulse request
  input  wire logic         pat_go,    // pattern pulse request
  input  wire logic         start_req, // start from block
  input  wire logic         abort_req, // abort from block
  output logic      [255:0] irq_lines, // interrupt sources
  output logic              pat_match, // pattern match pulse
  output int                start_cnt, // starts seen
  output int                abort_cnt  // aborts seen
);
  // one-cycle pulse: the rising edge is the occurrence, released lines idle low
  initial begin
    irq_lines = '0;
    pat_match = 1'b0;
    start_cnt = 0;
    abort_cnt = 0;
    forever begin
      @(posedge clk);
      irq_lines <= fire ? (256'h1 << fire_num) : '0;
      pat_match <= pat_go;
      if (start_req === 1'b1) begin
        start_cnt <= start_cnt + 1;
      end
      if (abort_req === 1'b1) begin
        abort_cnt <= abort_cnt + 1;
      end
    end
  end
endmodule

// ---- testbench/dma_channel_event_control_tb_top.sv ----
// self-checking testbench of the channel event control block
`timescale 1ns/10ps
module dma_channel_event_control_tb_top;
  logic         clk;
  logic         rst;
  logic [31:0]  adr;
  logic [31:0]  wdat;
  logic [31:0]  rdat;
  logic         we;
  logic         cyc;
  logic         stb;
  logic         ack;
  logic [255:0] irq_lines;
  logic         pat_match;
  logic         start_req;
  logic         abort_req;
  logic         abort_flag;
  logic         busy;
  logic         irq;
  logic [7:0]   fire_num;
  logic         fire;
  logic         pat_go;
  int           start_cnt;
  int           abort_cnt;
  int           s0;
  int           a0;
  int           err_count = 0;
  int           comparisons = 0;

  dcec_top #(.NUM_IRQ(256)) uut (
    .REF_CLK(clk), .SYS_RST(rst), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_SEL_I(4'hf), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack),
    .IRQ_LINES(irq_lines), .PAT_MATCH(pat_match), .START_REQ(start_req), .ABORT_REQ(abort_req),
    .CHAN_ABORT_FLAG(abort_flag), .CHAN_BUSY(busy), .IRQ(irq));

  dcec_far_model far (
    .clk(clk), .fire_num(fire_num), .fire(fire), .pat_go(pat_go), .start_req(start_req),
    .abort_req(abort_req), .irq_lines(irq_lines), .pat_match(pat_match),
    .start_cnt(start_cnt), .abort_cnt(abort_cnt));

  // ============================================================
  // helpers
  task automatic conclude;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // classic single cycle, held until ack is sampled high
  task automatic xfer(input logic [31:0] a, input logic [31:0] d, input logic w, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t bus timeout", $time);
      conclude;
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, d, 1'b1, q);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(a, 32'h0, 1'b0, q);
    chk(q, e, "read value");
  endtask

  task automatic ev(input logic [7:0] n, input logic p);
    s0 = start_cnt;
    a0 = abort_cnt;
    @(posedge clk);
    fire_num <= n;
    fire <= ~p;
    pat_go <= p;
    @(posedge clk);
    fire <= 1'b0;
    pat_go <= 1'b0;
  endtask

  // request lands one edge after the line rises, its count one edge later
  task automatic expect_ev(input int es, input int ea);
    repeat (4) @(posedge clk);
    chk(32'(start_cnt - s0), 32'(es), "start count");
    chk(32'(abort_cnt - a0), 32'(ea), "abort count");
  endtask

  task automatic snap;
    s0 = start_cnt;
    a0 = abort_cnt;
  endtask

  // ============================================================
  // scenarios
  task automatic t_reset;
    rd(32'h0, 32'h00ff_ff00);
    rd(32'h40, 32'h0);
    chk({31'h0, irq}, 32'h0, "irq after reset");
  endtask

  task automatic t_fields;
    wr(32'h0, 32'hffff_ff3f);
    rd(32'h0, 32'h00ff_ff38);
    wr(32'h4, 32'h00ff_0000);
    rd(32'h0, 32'h0000_ff38);
    wr(32'h8, 32'h0012_0000);
    rd(32'h0, 32'h0012_ff38);
    wr(32'hc, 32'h0000_cb20);
    rd(32'h0, 32'h0012_3418);
  endtask

  task automatic t_trig;
    wr(32'h14, 32'h7);
    wr(32'h18, 32'h1);
    ev(8'h34, 1'b0);
    expect_ev(1, 0);
    chk({31'h0, busy}, 32'h1, "busy after start");
    ev(8'h12, 1'b0);
    expect_ev(0, 1);
    chk({30'h0, abort_flag, busy}, 32'h2, "flag set, idle");
    chk({31'h0, irq}, 32'h1, "irq raised");
    wr(32'h10, 32'h7);
    repeat (2) @(posedge clk);
    chk({30'h0, abort_flag, irq}, 32'h0, "flag cleared");
    rd(32'h10, 32'h0);
  endtask

  task automatic t_gate;
    wr(32'h0, 32'h0012_3400);
    ev(8'h34, 1'b0);
    expect_ev(0, 0);
    wr(32'h0, 32'h0012_3418);
    ev(8'h35, 1'b0);
    expect_ev(0, 0);
    wr(32'h0, 32'h0012_3480);
    wr(32'h0, 32'h0012_3410);
    ev(8'h12, 1'b0);
    expect_ev(0, 0);
    chk({31'h0, busy}, 32'h1, "abort trigger ignored");
  endtask

  task automatic t_force;
    wr(32'h0, 32'h0012_3400);
    wr(32'h14, 32'h0);
    wr(32'h10, 32'h7);
    snap;
    wr(32'h0, 32'h0012_3440);
    expect_ev(0, 1);
    chk({30'h0, abort_flag, irq}, 32'h2, "masked flag");
    snap;
    wr(32'h0, 32'h0012_3480);
    expect_ev(1, 0);
    rd(32'h0, 32'h0012_3400);
    wr(32'h14, 32'h1);
    rd(32'h14, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1, "unmasked irq");
    wr(32'h10, 32'h7);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
  endtask

  task automatic t_pattern;
    ev(8'h0, 1'b1);
    expect_ev(0, 0);
    wr(32'h0, 32'h0012_3420);
    ev(8'h0, 1'b1);
    expect_ev(0, 1);
    rd(32'h18, 32'h0);
  endtask

  task automatic t_both;
    wr(32'h18, 32'h1);
    wr(32'h0, 32'h0012_1298);
    repeat (4) @(posedge clk);
    ev(8'h12, 1'b0);
    expect_ev(0, 1);
    chk({31'h0, busy}, 32'h0, "nothing running");
  endtask

  // ============================================================
  // clock, reset and sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 32'h0;
    wdat = 32'h0;
    fire = 1'b0;
    fire_num = 8'h0;
    pat_go = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_fields;
    t_trig;
    t_gate;
    t_force;
    t_pattern;
    t_both;
    conclude;
  end
endmodule
